// >>> hdl/lan_cmd_regs.sv
// Command and setup-address registers of a network controller, on APB.
// Assumes transmit and setup engines on pclk that pulse their done inputs.
`default_nettype none

module lan_cmd_regs #(
    parameter int unsigned POLL_CYCLES = lan_cmd_pkg::POLL_CYCLES
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [lan_cmd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           tx_ring_accessed,
    input  wire logic                           setup_read_done,
    output logic                                tx_fetch_req,
    output logic                                setup_fetch_req,
    output logic                                engines_enable,
    output logic                                soft_reset,
    output logic      [23:0]                    setup_block_address
);

    function automatic logic hit(input logic [lan_cmd_pkg::ADDR_W-1:0] a,
                                 input logic [lan_cmd_pkg::ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    logic        access;
    logic        setup_ph;
    logic        mapped;
    logic        wr_data;
    logic        wr_index;
    logic        wr_cmd;
    logic        wr_low;
    logic        wr_high;
    logic        halt_set;
    logic        start_set;
    logic        setup_finish;
    logic        poll_tick;
    logic [15:0] addr_low;
    logic [7:0]  addr_high;
    logic [15:0] status_word;
    logic [15:0] sel_word;

    logic [1:0]  index_q;
    logic [1:0]  index_d;
    logic        halt_q;
    logic        halt_d;
    logic        run_q;
    logic        run_d;
    logic        setup_q;
    logic        setup_d;
    logic        demand_q;
    logic        demand_d;
    logic        done_q;
    logic        done_d;
    logic        poll_pending_q;
    logic        poll_pending_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    lan_cmd_pkg::run_state_t state_q;
    lan_cmd_pkg::run_state_t state_d;

    // Bus decode
    assign setup_ph = psel && !penable;
    assign access   = psel && penable;
    assign mapped   = hit(paddr, lan_cmd_pkg::OFS_DATA) || hit(paddr, lan_cmd_pkg::OFS_INDEX);
    assign wr_data  = access && pwrite && hit(paddr, lan_cmd_pkg::OFS_DATA);
    assign wr_index = access && pwrite && hit(paddr, lan_cmd_pkg::OFS_INDEX);
    assign wr_cmd   = wr_data && (index_q == lan_cmd_pkg::IDX_STATUS);
    assign wr_low   = wr_data && (index_q == lan_cmd_pkg::IDX_ADDR_LOW);
    assign wr_high  = wr_data && (index_q == lan_cmd_pkg::IDX_ADDR_HIGH);

    // Zero wait states: read data was captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_q;

    assign halt_set  = wr_cmd && pwdata[lan_cmd_pkg::BIT_HALT];
    assign start_set = wr_cmd && !pwdata[lan_cmd_pkg::BIT_HALT]
                       && (pwdata[lan_cmd_pkg::BIT_RUN] || pwdata[lan_cmd_pkg::BIT_SETUP]);

    assign setup_finish = (state_q == lan_cmd_pkg::ST_SETUP) && setup_read_done;

    always_comb begin
        index_d = index_q;
        if (wr_index) begin
            index_d = pwdata[1:0];
        end
    end

    // Command bits
    always_comb begin
        halt_d         = halt_q;
        run_d          = run_q;
        setup_d        = setup_q;
        demand_d       = demand_q;
        done_d         = done_q;
        poll_pending_d = poll_pending_q;
        if (halt_set) begin
            halt_d         = 1'b1;
            run_d          = 1'b0;
            setup_d        = 1'b0;
            demand_d       = 1'b0;
            done_d         = 1'b0;
            poll_pending_d = 1'b0;
        end else begin
            if (start_set) begin
                halt_d = 1'b0;
            end
            if (wr_cmd && pwdata[lan_cmd_pkg::BIT_RUN]) begin
                run_d = 1'b1;
            end
            if (wr_cmd && pwdata[lan_cmd_pkg::BIT_SETUP]) begin
                setup_d = 1'b1;
            end
            if (wr_cmd && pwdata[lan_cmd_pkg::BIT_DEMAND]) begin
                demand_d = 1'b1;
            end else if (tx_ring_accessed) begin
                demand_d = 1'b0;
            end
            // finish sets flag, set beats clear
            if (setup_finish) begin
                done_d = 1'b1;
            end else if (wr_cmd && pwdata[lan_cmd_pkg::BIT_DONE]) begin
                done_d = 1'b0;
            end
            if (poll_tick && state_q == lan_cmd_pkg::ST_RUN) begin
                poll_pending_d = 1'b1;
            end else if (tx_ring_accessed) begin
                poll_pending_d = 1'b0;
            end
        end
    end

    // Sequencing between idle, setup and run
    always_comb begin
        state_d = state_q;
        if (halt_set) begin
            state_d = lan_cmd_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                lan_cmd_pkg::ST_IDLE: begin
                    if (wr_cmd && pwdata[lan_cmd_pkg::BIT_SETUP]) begin
                        state_d = lan_cmd_pkg::ST_SETUP;
                    end else if (wr_cmd && pwdata[lan_cmd_pkg::BIT_RUN]) begin
                        state_d = lan_cmd_pkg::ST_RUN;
                    end
                end
                lan_cmd_pkg::ST_SETUP: begin
                    if (setup_read_done) begin
                        state_d = run_d ? lan_cmd_pkg::ST_RUN : lan_cmd_pkg::ST_IDLE;
                    end
                end
                lan_cmd_pkg::ST_RUN: begin
                    if (wr_cmd && pwdata[lan_cmd_pkg::BIT_SETUP]) begin
                        state_d = lan_cmd_pkg::ST_SETUP;
                    end
                end
                default: begin
                    state_d = lan_cmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read data for the coming access phase
    always_comb begin
        status_word                        = lan_cmd_pkg::REG_ZERO;
        status_word[lan_cmd_pkg::BIT_SETUP] = setup_q;
        status_word[lan_cmd_pkg::BIT_RUN]   = run_q;
        status_word[lan_cmd_pkg::BIT_HALT]  = halt_q;
        status_word[lan_cmd_pkg::BIT_DEMAND] = demand_q;
        status_word[lan_cmd_pkg::BIT_DONE]  = done_q;
        sel_word                           = lan_cmd_pkg::REG_ZERO;
        unique case (index_q)
            lan_cmd_pkg::IDX_STATUS:    sel_word = status_word;
            lan_cmd_pkg::IDX_ADDR_LOW:  sel_word = halt_q ? addr_low : lan_cmd_pkg::REG_ZERO;
            lan_cmd_pkg::IDX_ADDR_HIGH: sel_word = halt_q ? {8'h00, addr_high} : lan_cmd_pkg::REG_ZERO;
            default:                    sel_word = lan_cmd_pkg::REG_ZERO;
        endcase
        prdata_d = prdata_q;
        if (setup_ph && !pwrite) begin
            prdata_d = lan_cmd_pkg::RDATA_ZERO;
            if (hit(paddr, lan_cmd_pkg::OFS_DATA)) begin
                prdata_d[lan_cmd_pkg::REG_W-1:0] = sel_word;
            end else if (hit(paddr, lan_cmd_pkg::OFS_INDEX)) begin
                prdata_d[1:0] = index_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q        <= lan_cmd_pkg::IDX_RESET;
            halt_q         <= lan_cmd_pkg::HALT_RESET;
            run_q          <= 1'b0;
            setup_q        <= 1'b0;
            demand_q       <= 1'b0;
            done_q         <= 1'b0;
            poll_pending_q <= 1'b0;
            state_q        <= lan_cmd_pkg::ST_IDLE;
            prdata_q       <= lan_cmd_pkg::RDATA_ZERO;
        end else begin
            index_q        <= index_d;
            halt_q         <= halt_d;
            run_q          <= run_d;
            setup_q        <= setup_d;
            demand_q       <= demand_d;
            done_q         <= done_d;
            poll_pending_q <= poll_pending_d;
            state_q        <= state_d;
            prdata_q       <= prdata_d;
        end
    end

    // Timer restarts whenever not running, so the first poll is a full interval
    ring_poll_timer #(
        .POLL_CYCLES (POLL_CYCLES)
    ) u_poll (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (state_q != lan_cmd_pkg::ST_RUN),
        .tick    (poll_tick)
    );

    setup_addr_store u_addr (
        .pclk      (pclk),
        .halted    (halt_q),
        .wr_low    (wr_low),
        .wr_high   (wr_high),
        .wdata     (pwdata[15:0]),
        .addr_low  (addr_low),
        .addr_high (addr_high)
    );

    assign engines_enable      = state_q == lan_cmd_pkg::ST_RUN;
    assign tx_fetch_req        = engines_enable && (demand_q || poll_pending_q);
    assign setup_fetch_req     = state_q == lan_cmd_pkg::ST_SETUP;
    assign soft_reset          = halt_q;
    assign setup_block_address = {addr_high, addr_low};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start_both;
        wr_cmd && pwdata[lan_cmd_pkg::BIT_RUN] && pwdata[lan_cmd_pkg::BIT_SETUP]
        && !pwdata[lan_cmd_pkg::BIT_HALT] && state_q == lan_cmd_pkg::ST_IDLE;
    endsequence

    sequence s_setup_then_run;
        setup_fetch_req && !engines_enable ##1 (setup_fetch_req && !engines_enable)[*1];
    endsequence

    AST_HALT_CLEARS: assert property (halt_set |=> halt_q && !run_q && !setup_q && !demand_q)
        else $error("halt write did not clear command bits");
    AST_HALT_PRIORITY: assert property (
        wr_cmd && pwdata[2:0] == 3'h7 |=> halt_q && !run_q && !setup_q && !engines_enable)
        else $error("halt did not override start bits");
    AST_HALT_HOLDS: assert property (halt_q && !start_set |=> halt_q)
        else $error("halt released without start write");
    AST_HALT_IDLE: assert property (halt_q |-> !engines_enable && !setup_fetch_req && !tx_fetch_req)
        else $error("activity while halted");
    AST_RUN_STICKY: assert property (run_q && !halt_set |=> run_q)
        else $error("run bit dropped without halt");
    AST_DEMAND_SELF_CLEAR: assert property (
        demand_q && tx_ring_accessed && !wr_cmd |=> !demand_q)
        else $error("demand not cleared after ring access");
    AST_SETUP_FIRST: assert property (
        s_start_both ##1 (!setup_read_done && !halt_set) |-> s_setup_then_run)
        else $error("run began before setup");
    AST_DEMAND_FETCH: assert property (engines_enable && demand_q |-> tx_fetch_req)
        else $error("demand did not request a fetch");
    AST_DONE_SET: assert property (setup_finish && !halt_set |=> done_q && !setup_fetch_req)
        else $error("setup complete flag not set");
    AST_ADDR_LOCKED: assert property (!halt_q |=> $stable(addr_low) && $stable(addr_high))
        else $error("setup address changed while not halted");
    AST_LOW_WRITE: assert property (wr_low && halt_q |=> addr_low == {$past(pwdata[15:1]), 1'b0})
        else $error("setup address low write not stored with bit 0 zero");
    AST_HIGH_WRITE: assert property (
        wr_high && halt_q |=> addr_high == $past(pwdata[lan_cmd_pkg::HIGH_W-1:0]))
        else $error("setup address high write not stored");
    AST_RESET_HALTED: assert property ($rose(presetn) |-> halt_q && state_q == lan_cmd_pkg::ST_IDLE)
        else $error("not halted after reset");

endmodule // lan_cmd_regs

`default_nettype wire

// >>> hdl/lan_cmd_pkg.sv
// Constants shared by the command register block and its helpers.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
`default_nettype none

package lan_cmd_pkg;

    // APB byte addresses of the two ports
    localparam logic [11:0] OFS_DATA        = 12'h000;
    localparam logic [11:0] OFS_INDEX       = 12'h004;
    localparam int          ADDR_W          = 12;

    // Register index pointer values
    localparam logic [1:0]  IDX_STATUS      = 2'h0;
    localparam logic [1:0]  IDX_ADDR_LOW    = 2'h1;
    localparam logic [1:0]  IDX_ADDR_HIGH   = 2'h2;
    localparam logic [1:0]  IDX_RESET       = 2'h0;

    // Field positions in command_status
    localparam int          BIT_SETUP       = 0;
    localparam int          BIT_RUN         = 1;
    localparam int          BIT_HALT        = 2;
    localparam int          BIT_DEMAND      = 3;
    localparam int          BIT_DONE        = 8;
    localparam int          REG_W           = 16;
    localparam int          HIGH_W          = 8;

    localparam logic        HALT_RESET      = 1'b1;
    localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
    localparam logic [15:0] REG_ZERO        = 16'h0000;

    // Descriptor ring poll interval
    localparam int unsigned POLL_TIME_NS    = 1_600_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned POLL_CYCLES     = POLL_TIME_NS / CLK_PERIOD_NS;
    localparam int          POLL_W          = 14;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SETUP = 3'h2,
        ST_RUN   = 3'h4
    } run_state_t;

endpackage : lan_cmd_pkg

`default_nettype wire

// >>> hdl/ring_poll_timer.sv
// Periodic ring poll timer: one-cycle tick every POLL_CYCLES cycles.
// Assumes clear is a synchronous level from the same clock domain.
`default_nettype none

module ring_poll_timer #(
    parameter int unsigned POLL_CYCLES = lan_cmd_pkg::POLL_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clear,
    output logic      tick
);

    logic [lan_cmd_pkg::POLL_W-1:0] count_q;
    logic [lan_cmd_pkg::POLL_W-1:0] count_d;
    logic                           tick_d;

    always_comb begin
        tick_d  = 1'b0;
        count_d = count_q + 1'b1;
        if (clear) begin
            count_d = '0;
        end else if (count_q == lan_cmd_pkg::POLL_W'(POLL_CYCLES - 1)) begin
            count_d = '0;
            tick_d  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else begin
            count_q <= count_d;
            tick    <= tick_d;
        end
    end

endmodule // ring_poll_timer

`default_nettype wire

// >>> hdl/setup_addr_store.sv
// Holds the 24-bit setup block address; writes only land while halted.
// Contents survive reset on purpose, so no reset branch exists.
`default_nettype none

module setup_addr_store (
    input  wire logic        pclk,
    input  wire logic        halted,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [15:0] wdata,
    output logic      [15:0] addr_low,
    output logic      [7:0]  addr_high
);

    logic [15:1] low_q;
    logic [15:1] low_d;
    logic [7:0]  high_q;
    logic [7:0]  high_d;

    always_comb begin
        low_d  = low_q;
        high_d = high_q;
        if (halted && wr_low) begin
            low_d = wdata[15:1];
        end
        if (halted && wr_high) begin
            high_d = wdata[lan_cmd_pkg::HIGH_W-1:0];
        end
    end

    always_ff @(posedge pclk) begin
        low_q  <= low_d;
        high_q <= high_d;
    end

    assign addr_low  = {low_q, 1'b0};
    assign addr_high = high_q;

endmodule // setup_addr_store

`default_nettype wire

// >>> bench/engine_model.sv
// Behavioural transmit and setup engines facing the command register block.
// Assumes requests are levels on pclk; each done pulse lasts one cycle.
`default_nettype none

module engine_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       soft_reset,
    input  wire logic       tx_fetch_req,
    input  wire logic       setup_fetch_req,
    input  wire logic [3:0] delay,
    output logic            tx_ring_accessed,
    output logic            setup_read_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] tx_cnt_q;
    logic [3:0] su_cnt_q;

    // Counters restart after each pulse so a request still high is not answered twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q         <= 4'h0;
            su_cnt_q         <= 4'h0;
            tx_ring_accessed <= 1'b0;
            setup_read_done  <= 1'b0;
        end else begin
            tx_ring_accessed <= 1'b0;
            setup_read_done  <= 1'b0;
            if (soft_reset || !tx_fetch_req || tx_ring_accessed) begin
                tx_cnt_q <= 4'h0;
            end else if (tx_cnt_q == delay) begin
                tx_ring_accessed <= 1'b1;
                tx_cnt_q         <= 4'h0;
            end else begin
                tx_cnt_q <= tx_cnt_q + 4'h1;
            end
            if (soft_reset || !setup_fetch_req || setup_read_done) begin
                su_cnt_q <= 4'h0;
            end else if (su_cnt_q == delay) begin
                setup_read_done <= 1'b1;
                su_cnt_q        <= 4'h0;
            end else begin
                su_cnt_q <= su_cnt_q + 4'h1;
            end
        end
    end
endmodule // engine_model

`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the command register block over APB.
// Assumes the package and design files under hdl/ are compiled first.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned POLL = 20;
    localparam int          AW   = lan_cmd_pkg::ADDR_W;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          tx_ring_accessed;
    logic          setup_read_done;
    logic          tx_fetch_req;
    logic          setup_fetch_req;
    logic          engines_enable;
    logic          soft_reset;
    logic [23:0]   setup_block_address;
    logic [3:0]    delay;
    logic [31:0]   rd;
    logic          err;
    int            n_mismatch;
    int            cmp_count;
    int            cycles;
    int            gap;

    lan_cmd_regs #(.POLL_CYCLES(POLL)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_ring_accessed(tx_ring_accessed), .setup_read_done(setup_read_done),
        .tx_fetch_req(tx_fetch_req), .setup_fetch_req(setup_fetch_req),
        .engines_enable(engines_enable), .soft_reset(soft_reset),
        .setup_block_address(setup_block_address)
    );

    engine_model u_eng (
        .pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .tx_fetch_req(tx_fetch_req),
        .setup_fetch_req(setup_fetch_req), .delay(delay),
        .tx_ring_accessed(tx_ring_accessed), .setup_read_done(setup_read_done)
    );

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Runs well under this; a hang is cut short here
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // Starts after an edge, so back-to-back calls leave one idle cycle
    task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [1:0] idx, input logic [31:0] v);
        apb(1'b1, lan_cmd_pkg::OFS_INDEX, {30'h0000_0000, idx});
        apb(1'b1, lan_cmd_pkg::OFS_DATA, v);
    endtask

    task automatic rd_reg(input logic [1:0] idx);
        apb(1'b1, lan_cmd_pkg::OFS_INDEX, {30'h0000_0000, idx});
        apb(1'b0, lan_cmd_pkg::OFS_DATA, 32'h0000_0000);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wait_lvl(input logic lvl);
        for (int i = 0; i < 60 && tx_fetch_req !== lvl; i++) @(negedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        delay = 4'h5;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_reg(2'h0);
        chk("status", 32'h0000_0004, rd);
        @(negedge pclk);
        chk_bit("soft_reset", 1'b1, soft_reset);
        $display("test reset done");
        wr_reg(2'h1, 32'h0000_beef);
        wr_reg(2'h2, 32'h0000_abcd);
        rd_reg(2'h1);
        chk("addr_low", 32'h0000_beee, rd);
        rd_reg(2'h2);
        chk("addr_high", 32'h0000_00cd, rd);
        chk("block_addr", 32'h00cd_beee, {8'h00, setup_block_address});
        $display("test setup address done");
        wr_reg(2'h0, 32'h0000_0003);
        @(negedge pclk);
        chk_bit("setup_fetch_req", 1'b1, setup_fetch_req);
        chk_bit("engines_enable", 1'b0, engines_enable);
        chk_bit("soft_reset", 1'b0, soft_reset);
        for (int i = 0; i < 60 && engines_enable !== 1'b1; i++) @(negedge pclk);
        chk_bit("engines_enable", 1'b1, engines_enable);
        chk_bit("setup_fetch_req", 1'b0, setup_fetch_req);
        rd_reg(2'h0);
        chk("status", 32'h0000_0103, rd);
        $display("test run with setup done");
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        gap = 0;
        while (gap < 60 && tx_fetch_req === 1'b1) begin
            @(negedge pclk);
            gap++;
        end
        while (gap < 60 && tx_fetch_req !== 1'b1) begin
            @(negedge pclk);
            gap++;
        end
        chk("poll_gap", 32'(POLL), 32'(gap));
        wait_lvl(1'b0);
        wr_reg(2'h0, 32'h0000_0008);
        @(negedge pclk);
        chk_bit("tx_fetch_req", 1'b1, tx_fetch_req);
        wait_lvl(1'b0);
        rd_reg(2'h0);
        chk("status", 32'h0000_0103, rd);
        $display("test poll and demand done");
        wr_reg(2'h0, 32'h0000_0000);
        rd_reg(2'h0);
        chk("status", 32'h0000_0103, rd);
        wr_reg(2'h1, 32'h0000_1234);
        rd_reg(2'h1);
        chk("addr_low", 32'h0000_0000, rd);
        chk_bit("pslverr", 1'b0, err);
        rd_reg(2'h3);
        chk("index3", 32'h0000_0000, rd);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk_bit("pslverr", 1'b1, err);
        chk("unmapped", 32'h0000_0000, rd);
        $display("test gating done");
        wr_reg(2'h0, 32'h0000_000f);
        @(negedge pclk);
        chk_bit("soft_reset", 1'b1, soft_reset);
        chk_bit("engines_enable", 1'b0, engines_enable);
        chk_bit("tx_fetch_req", 1'b0, tx_fetch_req);
        rd_reg(2'h0);
        chk("status", 32'h0000_0004, rd);
        rd_reg(2'h1);
        chk("addr_low", 32'h0000_beee, rd);
        $display("test halt done");
        wr_reg(2'h0, 32'h0000_0001);
        @(negedge pclk);
        for (int i = 0; i < 60 && setup_fetch_req !== 1'b0; i++) @(negedge pclk);
        rd_reg(2'h0);
        chk("status", 32'h0000_0101, rd);
        chk_bit("engines_enable", 1'b0, engines_enable);
        wr_reg(2'h0, 32'h0000_0002);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(negedge pclk);
        chk_bit("engines_enable", 1'b0, engines_enable);
        rd_reg(2'h0);
        chk("status", 32'h0000_0004, rd);
        rd_reg(2'h1);
        chk("addr_low", 32'h0000_beee, rd);
        rd_reg(2'h2);
        chk("addr_high", 32'h0000_00cd, rd);
        $display("test second reset done");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
